// [rtl/sac_pkg.sv]
// Contract
// - opcode 010 loads A with page word plus memory word plus special carry; status set.
// - when X selects the page, 010 adds the page word twice plus special carry.
// - opcode 013 loads A with inverted page word plus memory plus special carry.
// - opcode 011 loads A with page word plus inverted A plus special carry.
// - opcode 0B5 sets the special carry and sets status.
// - opcode 0B1 sets sum latch until return; clear latch means subtraction behaviour.
// - opcodes 0D0-0DF store A to memory, then add constant to A; status set.
// - store-add with sum latch set: special carry = previous carry OR own carry.
// - store-add with sum latch clear: special carry copies previous carry.
// - opcode 018 stores A only when sum latch equals special carry.
// - opcode 018 then decrements Y; status is one unless Y wrapped to 15.
// - opcode 012 puts special carry into A bit 0, upper bits zero; status set.
// - opcode 0B3 sets branch latch until return and sets status.
// - opcode 001 status = carry of memory minus A; A and memory unchanged.
// - opcodes 0E0-0EF status = carry of constant minus A; A unchanged.
package sac_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_OPCODE = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_XREG = 8'h08;
  localparam logic [7:0] ADDR_YREG = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_MEMDATA = 8'h14;

  // flags register: busy bit position
  localparam int FLAGS_BUSY_BIT = 8;

  // opcodes
  localparam logic [8:0] OPC_ADD_PAGE_MEM = 9'h010;
  localparam logic [8:0] OPC_ADD_INVPAGE_MEM = 9'h013;
  localparam logic [8:0] OPC_ADD_PAGE_INVACC = 9'h011;
  localparam logic [8:0] OPC_CLEAR_SPECIAL = 9'h0B4;
  localparam logic [8:0] OPC_SET_SPECIAL = 9'h0B5;
  localparam logic [8:0] OPC_SET_SUM_LATCH = 9'h0B1;
  localparam logic [8:0] OPC_SET_BRANCH = 9'h0B3;
  localparam logic [8:0] OPC_COND_STORE_DEC = 9'h018;
  localparam logic [8:0] OPC_FLAG_TO_ACC = 9'h012;
  localparam logic [8:0] OPC_CMP_LE_MEM = 9'h001;
  localparam logic [4:0] OPC_STORE_ADD_HI = 5'h0D;
  localparam logic [4:0] OPC_CMP_LE_CONST_HI = 5'h0E;
  localparam logic [8:0] OPC_RETURN_DEFAULT = 9'h00F;

  // page addressing and Y wrap value
  localparam logic [3:0] PAGE_ROW = 4'hF;
  localparam logic [3:0] PAGE_ALIAS_ROW = 4'h7;
  localparam logic [3:0] Y_WRAP = 4'hF;
  localparam logic [3:0] Y_DEC_ADDEND = 4'hF;

  // reset values
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [8:0] RST_OPCODE = 9'h000;

  typedef struct packed {
    logic branch_latch;
    logic sum_latch;
    logic alu_carry;
    logic special_carry;
    logic status;
  } sac_flags_t;

  localparam sac_flags_t RST_FLAGS = 5'h00;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
  } sac_bus_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_EXEC = 3'b100
  } sac_state_t;

endpackage

// [rtl/sac_nibble_mem.sv]
`timescale 1ns/100ps
module sac_nibble_mem #(
  parameter int AW = 8,
  parameter int DW = 4
) (
  // clock
  input logic clk,
  // write port
  input logic we,
  input logic [AW-1:0] waddr,
  input logic [DW-1:0] wdata,
  // two registered read ports
  input logic [AW-1:0] raddr_a,
  input logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_a,
  output logic [DW-1:0] rdata_b
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  // contents are not reset; software initialises the words it uses
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_a <= mem_q[raddr_a];
    rdata_b <= mem_q[raddr_b];
  end
endmodule

// [rtl/sac_alu_top.sv]
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module sac_alu_top #(
  parameter logic [8:0] OPC_RETURN = sac_pkg::OPC_RETURN_DEFAULT
) (
  // clock and reset
  input logic CLK_SYS,
  input logic RST,
  // ahb-lite slave
  input logic HSEL,
  input logic [31:0] HADDR,
  input logic [1:0] HTRANS,
  input logic HWRITE,
  input logic [2:0] HSIZE,
  input logic [31:0] HWDATA,
  input logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);

  function automatic logic [4:0] add4(input logic [3:0] a, input logic [3:0] b, input logic cin);
    return {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction

  // rows 7 and F both reach the page, so fold them onto one row
  function automatic logic [7:0] word_addr(input logic [3:0] x, input logic [3:0] y);
    return {((x == sac_pkg::PAGE_ALIAS_ROW) ? sac_pkg::PAGE_ROW : x), y};
  endfunction

  sac_pkg::sac_state_t state_q;
  sac_pkg::sac_flags_t flags_q;
  sac_pkg::sac_flags_t flags_d;
  sac_pkg::sac_bus_req_t req_q;
  logic req_valid_q;
  logic [8:0] opc_q;
  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic [3:0] x_q;
  logic [3:0] y_q;
  logic [3:0] y_d;
  logic [3:0] mem_rd;
  logic [3:0] page_rd;
  logic [3:0] mem_w;
  logic [3:0] konst;
  logic [4:0] res;
  logic x_is_page;
  logic exec;
  logic idle;
  logic exec_we;
  logic bus_wr;
  logic mem_we;
  logic [3:0] mem_wdata;
  logic [31:0] rd_mux;
  logic take;

  assign exec = (state_q == sac_pkg::ST_EXEC);
  assign idle = (state_q == sac_pkg::ST_IDLE);
  assign x_is_page = (x_q == sac_pkg::PAGE_ROW) || (x_q == sac_pkg::PAGE_ALIAS_ROW);
  assign konst = opc_q[3:0];
  // with the page selected both ports read the same word
  assign mem_w = x_is_page ? page_rd : mem_rd;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign bus_wr = req_valid_q && req_q.write;

  sac_nibble_mem #(
    .AW(8),
    .DW(4)
  ) u_mem (
    .clk(CLK_SYS),
    .we(mem_we),
    .waddr(word_addr(x_q, y_q)),
    .wdata(mem_wdata),
    .raddr_a(word_addr(x_q, y_q)),
    .raddr_b(word_addr(sac_pkg::PAGE_ROW, y_q)),
    .rdata_a(mem_rd),
    .rdata_b(page_rd)
  );

  // instruction datapath: next values for acc, y and flags
  always_comb begin
    acc_d = acc_q;
    y_d = y_q;
    flags_d = flags_q;
    exec_we = 1'b0;
    res = 5'h00;
    if (exec) begin
      if (opc_q == sac_pkg::OPC_ADD_PAGE_MEM) begin
        res = add4(page_rd, mem_w, flags_q.special_carry);
        acc_d = res[3:0];
        flags_d.alu_carry = res[4];
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_ADD_INVPAGE_MEM) begin
        res = add4(~page_rd, mem_w, flags_q.special_carry);
        acc_d = res[3:0];
        flags_d.alu_carry = res[4];
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_ADD_PAGE_INVACC) begin
        res = add4(page_rd, ~acc_q, flags_q.special_carry);
        acc_d = res[3:0];
        flags_d.alu_carry = res[4];
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_CLEAR_SPECIAL) begin
        flags_d.special_carry = 1'b0;
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_SET_SPECIAL) begin
        flags_d.special_carry = 1'b1;
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_SET_SUM_LATCH) begin
        // special carry left untouched; software re-seeds it afterwards
        flags_d.sum_latch = 1'b1;
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_SET_BRANCH) begin
        flags_d.branch_latch = 1'b1;
        flags_d.status = 1'b1;
      end else if (opc_q[8:4] == sac_pkg::OPC_STORE_ADD_HI) begin
        exec_we = 1'b1;
        res = add4(acc_q, konst, 1'b0);
        acc_d = res[3:0];
        flags_d.alu_carry = res[4];
        flags_d.status = 1'b1;
        if (flags_q.sum_latch) begin
          flags_d.special_carry = flags_q.alu_carry | res[4];
        end else begin
          flags_d.special_carry = flags_q.alu_carry;
        end
      end else if (opc_q == sac_pkg::OPC_COND_STORE_DEC) begin
        exec_we = (flags_q.sum_latch == flags_q.special_carry);
        res = add4(y_q, sac_pkg::Y_DEC_ADDEND, 1'b0);
        y_d = res[3:0];
        flags_d.status = (res[3:0] != sac_pkg::Y_WRAP);
      end else if (opc_q == sac_pkg::OPC_FLAG_TO_ACC) begin
        acc_d = {3'b000, flags_q.special_carry};
        flags_d.status = 1'b1;
      end else if (opc_q == sac_pkg::OPC_CMP_LE_MEM) begin
        res = add4(mem_w, ~acc_q, 1'b1);
        flags_d.status = res[4];
      end else if (opc_q[8:4] == sac_pkg::OPC_CMP_LE_CONST_HI) begin
        res = add4(konst, ~acc_q, 1'b1);
        flags_d.status = res[4];
      end else if (opc_q == OPC_RETURN) begin
        flags_d.sum_latch = 1'b0;
        flags_d.branch_latch = 1'b0;
      end
    end
  end

  // memory write: store of old A during execute, or direct software write when idle
  always_comb begin
    mem_we = exec_we || (idle && bus_wr && (req_q.addr == sac_pkg::ADDR_MEMDATA));
    mem_wdata = exec ? acc_q : HWDATA[3:0];
  end

  // sequencer: an opcode write is taken only while idle, one fetch cycle then execute
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= sac_pkg::ST_IDLE;
      opc_q <= sac_pkg::RST_OPCODE;
    end else begin
      unique case (state_q)
        sac_pkg::ST_IDLE: begin
          if (bus_wr && (req_q.addr == sac_pkg::ADDR_OPCODE)) begin
            opc_q <= HWDATA[8:0];
            state_q <= sac_pkg::ST_FETCH;
          end
        end
        sac_pkg::ST_FETCH: begin
          state_q <= sac_pkg::ST_EXEC;
        end
        sac_pkg::ST_EXEC: begin
          state_q <= sac_pkg::ST_IDLE;
        end
        default: begin
          state_q <= sac_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // flags change only through the datapath, never by a bus write
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      flags_q <= sac_pkg::RST_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      acc_q <= sac_pkg::RST_NIBBLE;
    end else if (idle && bus_wr && (req_q.addr == sac_pkg::ADDR_ACC)) begin
      acc_q <= HWDATA[3:0];
    end else begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      x_q <= sac_pkg::RST_NIBBLE;
    end else if (idle && bus_wr && (req_q.addr == sac_pkg::ADDR_XREG)) begin
      x_q <= HWDATA[3:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      y_q <= sac_pkg::RST_NIBBLE;
    end else if (idle && bus_wr && (req_q.addr == sac_pkg::ADDR_YREG)) begin
      y_q <= HWDATA[3:0];
    end else begin
      y_q <= y_d;
    end
  end

  // bus slave: zero wait states, read data registered at the end of the address phase
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (HADDR[7:0])
      sac_pkg::ADDR_OPCODE: rd_mux[8:0] = opc_q;
      sac_pkg::ADDR_ACC: rd_mux[3:0] = acc_q;
      sac_pkg::ADDR_XREG: rd_mux[3:0] = x_q;
      sac_pkg::ADDR_YREG: rd_mux[3:0] = y_q;
      sac_pkg::ADDR_FLAGS: begin
        rd_mux[4:0] = flags_q;
        rd_mux[sac_pkg::FLAGS_BUSY_BIT] = !idle;
      end
      sac_pkg::ADDR_MEMDATA: rd_mux[3:0] = mem_rd;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (HADDR[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      req_valid_q <= 1'b0;
      req_q <= '0;
    end else begin
      req_valid_q <= take && (HADDR[31:8] == 24'h00_0000);
      req_q.write <= HWRITE;
      req_q.addr <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (take && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  AST_PAGE_MEM_SUM: assert property (
    exec && opc_q == sac_pkg::OPC_ADD_PAGE_MEM && !x_is_page |=>
      {flags_q.alu_carry, acc_q} == ({1'b0, $past(page_rd)} + {1'b0, $past(mem_rd)}
        + {4'h0, $past(flags_q.special_carry)}) && flags_q.status)
    else $error("page plus memory sum wrong");

  AST_PAGE_DOUBLED: assert property (
    exec && opc_q == sac_pkg::OPC_ADD_PAGE_MEM && x_is_page |=>
      {flags_q.alu_carry, acc_q} == ({$past(page_rd), 1'b0} + {4'h0, $past(flags_q.special_carry)}))
    else $error("doubled page sum wrong");

  AST_INVPAGE_SUM: assert property (
    exec && opc_q == sac_pkg::OPC_ADD_INVPAGE_MEM |=>
      acc_q == 4'($past(~page_rd) + $past(mem_w) + {3'b000, $past(flags_q.special_carry)}))
    else $error("inverted page sum wrong");

  AST_INVACC_SUM: assert property (
    exec && opc_q == sac_pkg::OPC_ADD_PAGE_INVACC |=>
      acc_q == 4'($past(page_rd) + ~$past(acc_q) + {3'b000, $past(flags_q.special_carry)}))
    else $error("page plus inverted acc wrong");

  AST_SEED_SPECIAL: assert property (
    exec && (opc_q == sac_pkg::OPC_CLEAR_SPECIAL || opc_q == sac_pkg::OPC_SET_SPECIAL) |=>
      flags_q.special_carry == $past(opc_q[0]) && flags_q.status)
    else $error("special carry seed wrong");

  AST_LATCH_HELD: assert property (
    $fell(flags_q.sum_latch) || $fell(flags_q.branch_latch) |->
      $past(exec) && $past(opc_q) == OPC_RETURN)
    else $error("latch cleared without return");

  AST_STORE_ADD: assert property (
    exec && opc_q[8:4] == sac_pkg::OPC_STORE_ADD_HI |-> mem_we && mem_wdata == acc_q ##1
      acc_q == 4'($past(acc_q) + $past(konst)) && flags_q.special_carry ==
      ($past(flags_q.alu_carry) | ($past(flags_q.sum_latch) &&
      ({1'b0, $past(acc_q)} + {1'b0, $past(konst)} > 5'h0F))))
    else $error("store and add constant wrong");

  AST_COND_STORE: assert property (
    exec && opc_q == sac_pkg::OPC_COND_STORE_DEC |->
      mem_we == (flags_q.sum_latch ~^ flags_q.special_carry))
    else $error("conditional store wrong");

  AST_Y_DEC: assert property (
    exec && opc_q == sac_pkg::OPC_COND_STORE_DEC |=>
      y_q == 4'($past(y_q) - 4'h1) && flags_q.status == ($past(y_q) != 4'h0))
    else $error("index decrement wrong");

  AST_FLAG_TO_ACC: assert property (
    exec && opc_q == sac_pkg::OPC_FLAG_TO_ACC |=> acc_q == {3'b000, $past(flags_q.special_carry)})
    else $error("special carry copy wrong");

  AST_COMPARE: assert property (
    exec && (opc_q == sac_pkg::OPC_CMP_LE_MEM || opc_q[8:4] == sac_pkg::OPC_CMP_LE_CONST_HI) |=>
      $stable(acc_q) && !$past(mem_we) && flags_q.status ==
      ($past(acc_q) <= ((opc_q == sac_pkg::OPC_CMP_LE_MEM) ? $past(mem_w) : $past(konst))))
    else $error("less-or-equal compare wrong");

  AST_SPECIAL_STICKY: assert property (
    !exec |=> $stable(flags_q.special_carry))
    else $error("special carry changed outside execute");

  // bus writes are gated off while busy, so nothing may move during fetch
  AST_FETCH_HOLDS: assert property (
    state_q == sac_pkg::ST_FETCH |=>
      $stable(acc_q) && $stable(x_q) && $stable(y_q) && $stable(flags_q))
    else $error("state changed during fetch");

  AST_SEED_KEEPS_ACC: assert property (
    exec && (opc_q == sac_pkg::OPC_CLEAR_SPECIAL || opc_q == sac_pkg::OPC_SET_SPECIAL ||
      opc_q == sac_pkg::OPC_SET_SUM_LATCH || opc_q == sac_pkg::OPC_SET_BRANCH) |=> $stable(acc_q) && $stable(y_q))
    else $error("flag instruction changed acc or index");

  AST_SUM_LATCH_SET: assert property (
    exec && opc_q == sac_pkg::OPC_SET_SUM_LATCH |=>
      flags_q.sum_latch && flags_q.status && $stable(flags_q.special_carry))
    else $error("sum latch not set");

  AST_BRANCH_SET: assert property (
    exec && opc_q == sac_pkg::OPC_SET_BRANCH |=> flags_q.branch_latch && flags_q.status)
    else $error("branch latch not set");

  AST_RETURN_CLEARS: assert property (
    exec && opc_q == OPC_RETURN |=> !flags_q.sum_latch && !flags_q.branch_latch)
    else $error("return left a latch set");

  AST_COND_STORE_DATA: assert property (
    exec && opc_q == sac_pkg::OPC_COND_STORE_DEC && mem_we |-> mem_wdata == acc_q)
    else $error("conditional store data wrong");

  AST_SET_STATUS: assert property (
    exec && (opc_q == sac_pkg::OPC_ADD_INVPAGE_MEM || opc_q == sac_pkg::OPC_ADD_PAGE_INVACC ||
      opc_q == sac_pkg::OPC_FLAG_TO_ACC) |=> flags_q.status)
    else $error("status not set");

  CV_ADD_CARRY: cover property (exec && opc_q == sac_pkg::OPC_ADD_PAGE_MEM ##1 flags_q.alu_carry);
  CV_SKIP_STORE: cover property (exec && opc_q == sac_pkg::OPC_COND_STORE_DEC && !mem_we);
  CV_RETURN: cover property (flags_q.sum_latch && flags_q.branch_latch ##[1:40] $fell(flags_q.sum_latch));
  CV_Y_WRAP: cover property (exec && opc_q == sac_pkg::OPC_COND_STORE_DEC && y_q == 4'h0);
  CV_SUB_COPY: cover property (exec && opc_q[8:4] == sac_pkg::OPC_STORE_ADD_HI && !flags_q.sum_latch
    && flags_q.alu_carry);
endmodule

// [bench/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [8:0] op;
    logic [3:0] a;
    logic [3:0] m;
    logic [3:0] p;
    logic s;
    logic [3:0] ea;
    logic es;
    logic ess;
    logic ec;
    logic cc;
  } sac_row_t;
  // op, acc, mem, page, ss before, acc after, status, ss, alu carry, carry checked
  localparam sac_row_t ROWS [12] = '{
    '{9'h010, 4'h0, 4'h9, 4'h8, 1'h1, 4'h2, 1'h1, 1'h1, 1'h1, 1'h1},
    '{9'h013, 4'h0, 4'h2, 4'h3, 1'h0, 4'hE, 1'h1, 1'h0, 1'h0, 1'h1},
    '{9'h011, 4'h2, 4'h0, 4'h5, 1'h1, 4'h3, 1'h1, 1'h1, 1'h1, 1'h1},
    '{9'h0E8, 4'h9, 4'h0, 4'h0, 1'h0, 4'h9, 1'h0, 1'h0, 1'h0, 1'h0},
    '{9'h012, 4'h9, 4'h0, 4'h0, 1'h1, 4'h1, 1'h1, 1'h1, 1'h0, 1'h0},
    '{9'h001, 4'h5, 4'h5, 4'h0, 1'h0, 4'h5, 1'h1, 1'h0, 1'h0, 1'h0},
    '{9'h001, 4'h6, 4'h5, 4'h0, 1'h0, 4'h6, 1'h0, 1'h0, 1'h0, 1'h0},
    '{9'h0E7, 4'h7, 4'h0, 4'h0, 1'h0, 4'h7, 1'h1, 1'h0, 1'h0, 1'h0},
    '{9'h0E0, 4'h1, 4'h0, 4'h0, 1'h1, 4'h1, 1'h0, 1'h1, 1'h0, 1'h0},
    '{9'h0EF, 4'hF, 4'h0, 4'h0, 1'h0, 4'hF, 1'h1, 1'h0, 1'h0, 1'h0},
    '{9'h0B4, 4'h3, 4'h0, 4'h0, 1'h1, 4'h3, 1'h1, 1'h0, 1'h0, 1'h0},
    '{9'h0B5, 4'h3, 4'h0, 4'h0, 1'h0, 4'h3, 1'h1, 1'h1, 1'h0, 1'h0}
  };
  logic clk_sys;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  int mismatches;
  int checked;

  sac_alu_top i_sac_alu_top (
    .CLK_SYS(clk_sys),
    .RST(rst),
    .HSEL(hsel),
    .HADDR(haddr),
    .HTRANS(htrans),
    .HWRITE(hwrite),
    .HSIZE(hsize),
    .HWDATA(hwdata),
    .HREADY(hreadyout),
    .HRDATA(hrdata),
    .HREADYOUT(hreadyout),
    .HRESP(hresp)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; the address phase is held until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask = 32'hFFFFFFFF);
    logic [31:0] v;
    xfer(1'b0, a, 32'h00000000, v);
    chk(v & mask, exp);
  endtask

  // writes issued while busy are dropped, so poll busy before going on
  task automatic exec(input logic [8:0] op);
    logic [31:0] f;
    int n;
    wr(sac_pkg::ADDR_OPCODE, {23'h000000, op});
    n = 0;
    f = 32'h00000100;
    while (f[sac_pkg::FLAGS_BUSY_BIT] !== 1'b0 && n < 20) begin
      xfer(1'b0, sac_pkg::ADDR_FLAGS, 32'h00000000, f);
      n++;
    end
    // a poll limit that runs out is a failure, not a silent skip
    if (f[sac_pkg::FLAGS_BUSY_BIT] !== 1'b0) begin
      mismatches++;
      $display("BAD %0t busy never cleared", $time);
    end
  endtask

  task automatic setmem(input logic [3:0] x, input logic [3:0] y, input logic [3:0] v);
    wr(sac_pkg::ADDR_XREG, {28'h0000000, x});
    wr(sac_pkg::ADDR_YREG, {28'h0000000, y});
    wr(sac_pkg::ADDR_MEMDATA, {28'h0000000, v});
  endtask

  // the memory read port is registered, hence the idle cycle
  task automatic mem_is(input logic [3:0] x, input logic [3:0] y, input logic [3:0] v);
    wr(sac_pkg::ADDR_XREG, {28'h0000000, x});
    wr(sac_pkg::ADDR_YREG, {28'h0000000, y});
    @(posedge clk_sys);
    reg_is(sac_pkg::ADDR_MEMDATA, {28'h0000000, v});
  endtask

  initial begin
    #(30000 * 50);
    mismatches++;
    test_done();
  end

  initial begin
    sac_row_t r;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    chk({30'h00000000, hreadyout, hresp}, 32'h00000002);
    reg_is(sac_pkg::ADDR_ACC, 32'h00000000);
    reg_is(sac_pkg::ADDR_YREG, 32'h00000000);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000000);
    for (int i = 0; i < 12; i++) begin
      r = ROWS[i];
      setmem(4'hF, 4'h5, r.p);
      setmem(4'h3, 4'h5, r.m);
      wr(sac_pkg::ADDR_ACC, {28'h0000000, r.a});
      exec(r.s ? sac_pkg::OPC_SET_SPECIAL : sac_pkg::OPC_CLEAR_SPECIAL);
      exec(r.op);
      reg_is(sac_pkg::ADDR_ACC, {28'h0000000, r.ea});
      reg_is(sac_pkg::ADDR_FLAGS, {29'h0, r.ec, r.ess, r.es}, {27'h0, 2'h3, r.cc, 2'h3});
    end
    // page selected by X itself, then through its alias
    setmem(4'hF, 4'h2, 4'h6);
    exec(sac_pkg::OPC_SET_SPECIAL);
    exec(sac_pkg::OPC_ADD_PAGE_MEM);
    reg_is(sac_pkg::ADDR_ACC, 32'h0000000D);
    setmem(4'h7, 4'h2, 4'h4);
    exec(sac_pkg::OPC_ADD_PAGE_MEM);
    reg_is(sac_pkg::ADDR_ACC, 32'h00000009);
    // addition mode
    exec(sac_pkg::OPC_SET_SUM_LATCH);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000009, 32'h00000019);
    exec(sac_pkg::OPC_CLEAR_SPECIAL);
    setmem(4'hF, 4'h5, 4'h8);
    setmem(4'h3, 4'h5, 4'h9);
    exec(sac_pkg::OPC_ADD_PAGE_MEM);
    exec(9'h0D6);
    reg_is(sac_pkg::ADDR_ACC, 32'h00000007);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000003, 32'h00000007);
    exec(sac_pkg::OPC_COND_STORE_DEC);
    reg_is(sac_pkg::ADDR_YREG, 32'h00000004);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000001);
    mem_is(4'h3, 4'h5, 4'h7);
    setmem(4'hF, 4'h5, 4'h1);
    setmem(4'h3, 4'h5, 4'h1);
    exec(sac_pkg::OPC_ADD_PAGE_MEM);
    exec(sac_pkg::OPC_CLEAR_SPECIAL);
    exec(9'h0DF);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000007, 32'h00000007);
    mem_is(4'h3, 4'h5, 4'h3);
    exec(sac_pkg::OPC_CLEAR_SPECIAL);
    exec(sac_pkg::OPC_COND_STORE_DEC);
    mem_is(4'h3, 4'h5, 4'h3);
    exec(sac_pkg::OPC_SET_BRANCH);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000019, 32'h00000019);
    exec(sac_pkg::OPC_RETURN_DEFAULT);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000000, 32'h00000018);
    // subtraction mode: previous carry is copied, own carry ignored
    setmem(4'hF, 4'h5, 4'h8);
    setmem(4'h3, 4'h5, 4'h9);
    exec(sac_pkg::OPC_CLEAR_SPECIAL);
    exec(sac_pkg::OPC_ADD_PAGE_MEM);
    exec(9'h0D0);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000003, 32'h00000007);
    setmem(4'hF, 4'h5, 4'h1);
    setmem(4'h3, 4'h5, 4'h1);
    exec(sac_pkg::OPC_ADD_PAGE_MEM);
    exec(9'h0DF);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000005, 32'h00000007);
    wr(sac_pkg::ADDR_YREG, 32'h00000000);
    exec(sac_pkg::OPC_COND_STORE_DEC);
    reg_is(sac_pkg::ADDR_YREG, 32'h0000000F);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000000, 32'h00000001);
    mem_is(4'h3, 4'h0, 4'h2);
    exec(sac_pkg::OPC_FLAG_TO_ACC);
    reg_is(sac_pkg::ADDR_ACC, 32'h00000000);
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000001, 32'h00000003);
    // a write that lands in the busy window is dropped
    wr(sac_pkg::ADDR_OPCODE, {23'h000000, sac_pkg::OPC_SET_SPECIAL});
    wr(sac_pkg::ADDR_ACC, 32'h00000005);
    reg_is(sac_pkg::ADDR_ACC, 32'h00000000);
    reg_is(sac_pkg::ADDR_OPCODE, {23'h000000, sac_pkg::OPC_SET_SPECIAL});
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000003, 32'h00000003);
    // reset in mid-run with a latch, special carry and acc all set
    exec(sac_pkg::OPC_SET_SUM_LATCH);
    wr(sac_pkg::ADDR_ACC, 32'h00000005);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    reg_is(sac_pkg::ADDR_FLAGS, 32'h00000000);
    reg_is(sac_pkg::ADDR_ACC, 32'h00000000);
    reg_is(sac_pkg::ADDR_XREG, 32'h00000000);
    // unmapped place reads zero and ignores writes
    wr(8'h40, 32'h00000005);
    reg_is(8'h40, 32'h00000000);
    test_done();
  end
endmodule
